// ===== hw/vdmm_pkg.sv
package vdmm_pkg;
    // soft switch locations
    localparam logic [15:0] VDMM_AUX_STORE_OFF_ADDR  = 16'hC000;
    localparam logic [15:0] VDMM_AUX_STORE_ON_ADDR   = 16'hC001;
    localparam logic [15:0] VDMM_AUX_STORE_READ_ADDR = 16'hC018;
    localparam logic [15:0] VDMM_PAGE_READ_ADDR      = 16'hC01C;
    localparam logic [15:0] VDMM_PAGE_FIRST_ADDR     = 16'hC054;
    localparam logic [15:0] VDMM_PAGE_SECOND_ADDR    = 16'hC055;
    localparam int          VDMM_STATE_BIT           = 7;
    // page bases
    localparam logic [15:0] VDMM_TEXT_BASE           = 16'h0400;
    localparam logic [15:0] VDMM_TEXT_PAGE2_OFFSET   = 16'h0400;
    localparam logic [15:0] VDMM_TEXT_PAGE_LAST      = 16'h07FF;
    localparam logic [15:0] VDMM_HIRES_BASE          = 16'h2000;
    localparam logic [15:0] VDMM_HIRES_PAGE2_OFFSET  = 16'h2000;
    localparam logic [15:0] VDMM_HIRES_PAGE_LAST     = 16'h3FFF;
    // folding
    localparam logic [15:0] VDMM_ROW_BYTES           = 16'h0028;
    localparam int          VDMM_BLOCK_SHIFT         = 7;
    localparam int          VDMM_DOT_BLOCK_SHIFT     = 10;
    localparam logic [5:0]  VDMM_LAST_COL            = 6'h27;
    localparam logic [7:0]  VDMM_LAST_LINE           = 8'hBF;
    // reset values
    localparam logic        VDMM_SWITCH_RESET        = 1'b0;
    typedef enum logic [0:0] {
        VDMM_PH_FETCH = 1'b0,
        VDMM_PH_SECOND = 1'b1
    } vdmm_phase_t;
endpackage : vdmm_pkg

// ===== hw/vdmm_top.sv
`timescale 1ns/1ps
module vdmm_top
    import vdmm_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic        cpu_rd_i,
    input  wire logic        cpu_wr_i,
    input  wire logic        mode_hires_i,
    input  wire logic        mode_col80_i,
    input  wire logic        mode_dhires_i,
    input  wire logic [7:0]  main_data_i,
    input  wire logic [7:0]  aux_data_i,
    output logic [7:0]       cpu_rdata_o,
    output logic             cpu_rdata_valid_o,
    output logic             cpu_to_aux_o,
    output logic [15:0]      fetch_addr_o,
    output logic [7:0]       video_byte_o,
    output logic             video_byte_valid_o,
    output logic             video_byte_aux_o
);
    logic        aux_store_enable_switch;
    logic        second_page_select_switch;
    vdmm_phase_t phase;
    logic [5:0]  col;
    logic [7:0]  line;
    logic [7:0]  main_hold;
    logic        interleave_hold;

    // switch decode
    wire access       = cpu_rd_i | cpu_wr_i;
    wire aux_on_hit   = cpu_wr_i & (cpu_addr_i == VDMM_AUX_STORE_ON_ADDR);
    wire aux_off_hit  = cpu_wr_i & (cpu_addr_i == VDMM_AUX_STORE_OFF_ADDR);
    wire page2_hit    = access & (cpu_addr_i == VDMM_PAGE_SECOND_ADDR);
    wire page1_hit    = access & (cpu_addr_i == VDMM_PAGE_FIRST_ADDR);
    wire rd_aux_hit   = cpu_rd_i & (cpu_addr_i == VDMM_AUX_STORE_READ_ADDR);
    wire rd_page_hit  = cpu_rd_i & (cpu_addr_i == VDMM_PAGE_READ_ADDR);
    wire [7:0] rd_val = rd_aux_hit  ? {aux_store_enable_switch, 7'h00}
                      : rd_page_hit ? {second_page_select_switch, 7'h00}
                      : 8'h00;

    // processor routing of page-one accesses
    wire in_text_p1  = (cpu_addr_i >= VDMM_TEXT_BASE)
                     & (cpu_addr_i <= VDMM_TEXT_PAGE_LAST);
    wire in_hires_p1 = mode_hires_i & (cpu_addr_i >= VDMM_HIRES_BASE)
                     & (cpu_addr_i <= VDMM_HIRES_PAGE_LAST);
    assign cpu_to_aux_o = aux_store_enable_switch & second_page_select_switch
                        & (in_text_p1 | in_hires_p1);

    // scan address generation
    wire interleave = mode_col80_i | (mode_dhires_i & mode_hires_i);
    wire use_page2  = second_page_select_switch & ~aux_store_enable_switch
                    & ~interleave;
    // three rows 64 apart share a 128-byte block, 120 bytes used
    wire [15:0] fold_off = 16'({line[5:3], 7'h00})
                         + 16'(line[7:6]) * VDMM_ROW_BYTES
                         + 16'(col);
    wire [15:0] text_addr = VDMM_TEXT_BASE + fold_off
                          + (use_page2 ? VDMM_TEXT_PAGE2_OFFSET
                                       : 16'h0000);
    wire [15:0] hires_addr = VDMM_HIRES_BASE + fold_off
                           + 16'({line[2:0], 10'h000})
                           + (use_page2 ? VDMM_HIRES_PAGE2_OFFSET
                                        : 16'h0000);
    wire [15:0] next_fetch_addr = mode_hires_i ? hires_addr : text_addr;
    wire        col_end  = (col == VDMM_LAST_COL);
    wire        line_end = (line == VDMM_LAST_LINE);
    wire [5:0]  next_col  = col_end ? 6'h00 : col + 6'h01;
    wire [7:0]  next_line = !col_end ? line
                          : line_end ? 8'h00 : line + 8'h01;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            aux_store_enable_switch   <= VDMM_SWITCH_RESET;
            second_page_select_switch <= VDMM_SWITCH_RESET;
            cpu_rdata_o               <= 8'h00;
            cpu_rdata_valid_o         <= 1'b0;
        end else begin
            if (aux_on_hit)
                aux_store_enable_switch <= 1'b1;
            else if (aux_off_hit)
                aux_store_enable_switch <= 1'b0;
            if (page2_hit)
                second_page_select_switch <= 1'b1;
            else if (page1_hit)
                second_page_select_switch <= 1'b0;
            cpu_rdata_o       <= rd_val;
            cpu_rdata_valid_o <= rd_aux_hit | rd_page_hit;
        end
    end

    // scan counters: one column every two clocks
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            phase        <= VDMM_PH_FETCH;
            col          <= 6'h00;
            line         <= 8'h00;
            fetch_addr_o <= VDMM_TEXT_BASE;
        end else begin
            unique case (phase)
                VDMM_PH_FETCH: begin
                    phase <= VDMM_PH_SECOND;
                end
                VDMM_PH_SECOND: begin
                    phase <= VDMM_PH_FETCH;
                    col   <= next_col;
                    line  <= next_line;
                end
            endcase
            if (phase == VDMM_PH_SECOND)
                fetch_addr_o <= next_fetch_addr;
        end
    end

    // byte output: when interleaved, aux byte (even column) then main byte (odd column); otherwise main byte only
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            main_hold          <= 8'h00;
            interleave_hold    <= 1'b0;
            video_byte_o       <= 8'h00;
            video_byte_valid_o <= 1'b0;
            video_byte_aux_o   <= 1'b0;
        end else if (phase == VDMM_PH_FETCH) begin
            main_hold          <= main_data_i;
            interleave_hold    <= interleave;
            video_byte_o       <= interleave ? aux_data_i
                                             : main_data_i;
            video_byte_valid_o <= 1'b1;
            video_byte_aux_o   <= interleave;
        end else begin
            video_byte_o       <= main_hold;
            video_byte_valid_o <= interleave_hold;
            video_byte_aux_o   <= 1'b0;
        end
    end
endmodule : vdmm_top

// ===== test/vdmm_sva.sv
`timescale 1ns/1ps
module vdmm_sva
    import vdmm_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic        cpu_rd_i,
    input wire logic        mode_hires_i,
    input wire logic        mode_col80_i,
    input wire logic        mode_dhires_i,
    input wire logic [7:0]  cpu_rdata_o,
    input wire logic        cpu_rdata_valid_o,
    input wire logic        cpu_to_aux_o,
    input wire logic [15:0] fetch_addr_o,
    input wire logic        video_byte_valid_o,
    input wire logic        video_byte_aux_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    a_aux_state_read: assert property (
        cpu_rd_i && cpu_addr_i == 16'hC018 |=> cpu_rdata_valid_o
        && cpu_rdata_o[6:0] == 7'h00) else $error("aux state read");
    a_page_state_read: assert property (
        cpu_rd_i && cpu_addr_i == 16'hC01C |=> cpu_rdata_valid_o)
        else $error("page state read");
    a_aux_route_window: assert property (cpu_to_aux_o |->
        cpu_addr_i inside {[16'h0400:16'h07FF]} || (mode_hires_i
        && cpu_addr_i inside {[16'h2000:16'h3FFF]})) else $error("route");
    a_pair_aux_first: assert property (
        video_byte_valid_o && video_byte_aux_o |=> video_byte_valid_o
        && !video_byte_aux_o) else $error("pair order");
    a_fetch_addr_stands: assert property (
        $changed(fetch_addr_o) |=> $stable(fetch_addr_o))
        else $error("fetch address held one cycle");
    a_col80_page_one: assert property ($changed(fetch_addr_o)
        && $past(mode_col80_i && !mode_hires_i)
        |-> fetch_addr_o inside {[16'h0400:16'h07FF]}) else $error("col80");
    a_dhires_page_one: assert property ($changed(fetch_addr_o)
        && $past(mode_hires_i && mode_dhires_i)
        |-> fetch_addr_o inside {[16'h2000:16'h3FFF]}) else $error("dhr");
    a_fold_tail_unused: assert property (
        fetch_addr_o[6:0] <= 7'h77) else $error("fold tail fetched");
endmodule : vdmm_sva
bind vdmm_top vdmm_sva u_vdmm_sva (.*);

// ===== test/vdmm_mem_model.sv
`timescale 1ns/1ps
module vdmm_mem_model
    import vdmm_pkg::*;
(
    input  wire logic [15:0] fetch_addr_i,
    output logic      [7:0]  main_data_o,
    output logic      [7:0]  aux_data_o
);
    // both banks answer the same address at once
    assign main_data_o = fetch_addr_i[7:0] ^ fetch_addr_i[15:8] ^ 8'h3C;
    assign aux_data_o  = ~main_data_o;
endmodule : vdmm_mem_model

// ===== test/vdmm_tb_top.sv
`timescale 1ns/1ps
module vdmm_tb_top
    import vdmm_pkg::*;
;
    typedef struct packed {logic [2:0] m; logic pg; logic ax;
        logic [15:0] msk; logic [15:0] base;} vdmm_row_t;
    logic        sys_clk_i = 1'h0, resetn_i = 1'h0;
    logic        cpu_rd_i = 1'h0, cpu_wr_i = 1'h0;
    logic        mode_hires_i = 1'h0, mode_col80_i = 1'h0;
    logic        mode_dhires_i = 1'h0;
    logic [15:0] cpu_addr_i = 16'h0000, fetch_addr_o, a;
    logic [7:0]  main_data_i, aux_data_i, cpu_rdata_o, video_byte_o;
    logic        cpu_rdata_valid_o, cpu_to_aux_o;
    logic        video_byte_valid_o, video_byte_aux_o;
    int          errors = 0, checked = 0, i;
    vdmm_row_t   rows [7] = '{'{3'h0, 1'h0, 1'h0, 16'hFC00, 16'h0400},
        '{3'h0, 1'h1, 1'h0, 16'hFC00, 16'h0800},
        '{3'h4, 1'h0, 1'h0, 16'hE000, 16'h2000},
        '{3'h4, 1'h1, 1'h0, 16'hE000, 16'h4000},
        '{3'h2, 1'h1, 1'h0, 16'hFC00, 16'h0400},
        '{3'h5, 1'h1, 1'h0, 16'hE000, 16'h2000},
        '{3'h0, 1'h1, 1'h1, 16'hFC00, 16'h0400}};
    vdmm_top u_vdmm_top (.sys_clk_i, .resetn_i, .cpu_addr_i, .cpu_rd_i,
        .cpu_wr_i, .mode_hires_i, .mode_col80_i, .mode_dhires_i,
        .main_data_i, .aux_data_i, .cpu_rdata_o, .cpu_rdata_valid_o,
        .cpu_to_aux_o, .fetch_addr_o, .video_byte_o, .video_byte_valid_o,
        .video_byte_aux_o);
    vdmm_mem_model u_vdmm_mem_model (.fetch_addr_i(fetch_addr_o),
        .main_data_o(main_data_i), .aux_data_o(aux_data_i));
    initial forever #50 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input logic r, w, input logic [15:0] ad);
        @(negedge sys_clk_i);
        {cpu_rd_i, cpu_wr_i, cpu_addr_i} = {r, w, ad};
        @(negedge sys_clk_i);
        {cpu_rd_i, cpu_wr_i} = 2'h0;
    endtask : acc
    task automatic end_of_test();
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4) @(negedge sys_clk_i);
        chk("reset_fetch", 16'h0400, fetch_addr_o);
        resetn_i = 1'h1;
        foreach (rows[k]) begin
            {mode_hires_i, mode_col80_i, mode_dhires_i} = rows[k].m;
            acc(1'h0, 1'h1, rows[k].pg ? 16'hC055 : 16'hC054);
            acc(1'h0, 1'h1, rows[k].ax ? 16'hC001 : 16'hC000);
            repeat (6) @(negedge sys_clk_i);
            chk("page", rows[k].base, fetch_addr_o & rows[k].msk);
        end
        cpu_addr_i = 16'h0500;
        #1 chk("to_aux", 16'h0001, {15'h0, cpu_to_aux_o});
        acc(1'h1, 1'h0, 16'hC018);
        chk("rd_aux", 16'h0180, {7'h0, cpu_rdata_valid_o, cpu_rdata_o});
        acc(1'h0, 1'h1, 16'hC054);
        cpu_addr_i = 16'h0500;
        #1 chk("to_main", 16'h0000, {15'h0, cpu_to_aux_o});
        acc(1'h1, 1'h0, 16'hC055);
        acc(1'h1, 1'h0, 16'hC01C);
        chk("rd_page", 16'h0180, {7'h0, cpu_rdata_valid_o, cpu_rdata_o});
        for (i = 0; i < 20 && !video_byte_valid_o; i++)
            @(negedge sys_clk_i);
        if (i == 20) begin
            errors++;
            end_of_test();
        end
        a = fetch_addr_o;
        chk("col40_byte", {7'h0, 1'h0, a[7:0] ^ a[15:8] ^ 8'h3C}, {video_byte_aux_o, video_byte_o});
        @(negedge sys_clk_i);
        chk("col40_gap", 16'h0000, {15'h0, video_byte_valid_o});
        mode_col80_i = 1'h1;
        for (i = 0; i < 20 && !(video_byte_valid_o && video_byte_aux_o); i++)
            @(negedge sys_clk_i);
        if (i == 20) begin
            errors++;
            end_of_test();
        end
        a = fetch_addr_o;
        chk("aux_byte", {8'h0, a[7:0] ^ a[15:8] ^ 8'hC3}, video_byte_o);
        @(negedge sys_clk_i);
        chk("main_byte", {7'h0, 1'h1, a[7:0] ^ a[15:8] ^ 8'h3C}, {video_byte_aux_o, video_byte_valid_o, video_byte_o});
        end_of_test();
    end
endmodule : vdmm_tb_top
